// ==== src/irq_router_defs.vh ====
// Purpose : Constants for the board interrupt source router
// Assumes : 10 MHz clock on mclk_i
// Notes   : Definitions only
`ifndef IRQ_ROUTER_DEFS_VH
`define IRQ_ROUTER_DEFS_VH

// ==================================================
// Source count and destination encoding
`define SRC_COUNT        28
`define DEST_W           4
`define DEST_NONE        4'h0
`define DEST_LEVEL_BASE  4'h1
`define DEST_NMI         4'h9
`define LEVEL_COUNT      8

// ==================================================
// Source index map
`define SRC_BUS_BASE     0
`define SRC_PAR_INFULL   8
`define SRC_PAR_OUTEMPTY 9
`define SRC_PAR_GENERAL  10
`define SRC_SER_TXEMPTY  11
`define SRC_SER_RXFULL   12
`define SRC_TMR_BASE     13
`define SRC_EXP_BASE     15
`define SRC_FAILSAFE     19
`define SRC_POWER_FAIL   20
`define SRC_LINE_CLOCK   21
`define SRC_EXTERNAL     22
`define SRC_COPROC       23
`define SRC_PARITY       24
`define SRC_EDGE_LEVEL   25
`define SRC_OR_BASE      26

// ==================================================
// Timing
`define FAILSAFE_US      6000
`define CLK_MHZ          10
`define FAILSAFE_CYCLES  (`FAILSAFE_US * `CLK_MHZ)
`define FS_CNT_W         16

`endif

// ==== src/irq_source_router.v ====
// What this block does
// - Any of 28 sources routes to any destination
// - Power-fail request qualified by mains-low warning
// - RAM protect low blocks all RAM access
// - Fail-safe timer requests after 6 msec silence
// - Eight system-bus request lines accepted
// - Parallel port gives three request sources
// - Serial port gives two request sources
// - Timer 0 and 1 outputs are sources
// - Two expansion connectors give four requests
// - Power-fail is one request line
// - 120 Hz line clock is a source
// - Coprocessor error is one source
// - Parity error is one source
// - One edge-to-level converter, routable
// - Two OR-gate outputs merge chosen sources
// - NMI direct; eight levels to controller
//
// Purpose : Strap matrix gathering board interrupt sources
// Assumes : All source pins asynchronous; straps static after reset
// Notes   : Route and OR-merge straps are plain input buses
`timescale 1ns/10ps
`include "irq_router_defs.vh"

module irq_source_router #(
  parameter FAILSAFE_CYCLES = `FAILSAFE_CYCLES
) (
  input  wire                           mclk_i,
  input  wire                           reset_n_i,
  input  wire [7:0]                     bus_request_i,
  input  wire                           par_input_full_i,
  input  wire                           par_output_empty_i,
  input  wire                           socket_general_request_i,
  input  wire                           ser_tx_empty_i,
  input  wire                           ser_rx_full_i,
  input  wire [1:0]                     timer_out_i,
  input  wire [3:0]                     expansion_request_i,
  input  wire                           bus_command_i,
  input  wire                           bus_acknowledge_i,
  input  wire                           power_fail_i,
  input  wire                           mains_low_warning_i,
  input  wire                           line_clock_i,
  input  wire                           auxiliary_backplane_request_i,
  input  wire                           coproc_error_i,
  input  wire                           parity_error_i,
  input  wire                           edge_request_i,
  input  wire                           edge_clear_i,
  input  wire [`SRC_COUNT*`DEST_W-1:0]  route_strap_i,
  input  wire [`SRC_OR_BASE-1:0]        or0_select_i,
  input  wire [`SRC_OR_BASE-1:0]        or1_select_i,
  input  wire                           ram_protect_n_i,
  input  wire                           ram_access_req_i,
  output wire                           ram_access_grant_o,
  output reg  [`LEVEL_COUNT-1:0]        controller_request_o,
  output reg                            nmi_request_o
);

  // ==================================================
  // Input synchronisers
  localparam NIN = 28;
  wire [NIN-1:0] raw_in;
  reg  [NIN-1:0] sync1_r;
  reg  [NIN-1:0] sync2_r;

  // Protect pin left out on purpose: it acts unsynchronised below
  assign raw_in = {edge_request_i, parity_error_i, coproc_error_i,
                   auxiliary_backplane_request_i, line_clock_i, mains_low_warning_i,
                   power_fail_i, bus_acknowledge_i, bus_command_i, expansion_request_i,
                   timer_out_i, ser_rx_full_i, ser_tx_empty_i, socket_general_request_i,
                   par_output_empty_i, par_input_full_i, bus_request_i};

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= {NIN{1'b0}};
      sync2_r <= {NIN{1'b0}};
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire [7:0] s_bus     = sync2_r[7:0];
  wire       s_par_if  = sync2_r[8];
  wire       s_par_oe  = sync2_r[9];
  wire       s_par_gen = sync2_r[10];
  wire       s_ser_tx  = sync2_r[11];
  wire       s_ser_rx  = sync2_r[12];
  wire [1:0] s_tmr     = sync2_r[14:13];
  wire [3:0] s_exp     = sync2_r[18:15];
  wire       s_cmd     = sync2_r[19];
  wire       s_ack     = sync2_r[20];
  wire       s_pfail   = sync2_r[21];
  wire       s_mlow    = sync2_r[22];
  wire       s_line    = sync2_r[23];
  wire       s_ext     = sync2_r[24];
  wire       s_copro   = sync2_r[25];
  wire       s_parity  = sync2_r[26];
  wire       s_edge    = sync2_r[27];

  // ==================================================
  // RAM protect
  // Protect pin kept raw so a falling supply blocks at once, not two clocks late
  // Block RAM access
  assign ram_access_grant_o = ram_access_req_i & ram_protect_n_i;

  // ==================================================
  // Edge-to-level converter
  reg edge_prev_r;
  reg edge_level_r;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_prev_r  <= 1'b0;
      edge_level_r <= 1'b0;
    end else begin
      edge_prev_r <= s_edge;
      if (s_edge & ~edge_prev_r)
        edge_level_r <= 1'b1;
      else if (edge_clear_i)
        edge_level_r <= 1'b0;
    end
  end

  // ==================================================
  // Bus fail-safe timer
  reg [`FS_CNT_W-1:0] fs_cnt_r;
  reg                 fs_run_r;
  reg                 fs_req_r;
  reg                 cmd_prev_r;
  wire                cmd_start = s_cmd & ~cmd_prev_r;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fs_cnt_r   <= {`FS_CNT_W{1'b0}};
      fs_run_r   <= 1'b0;
      fs_req_r   <= 1'b0;
      cmd_prev_r <= 1'b0;
    end else begin
      cmd_prev_r <= s_cmd;
      if (cmd_start) begin
        fs_cnt_r <= {`FS_CNT_W{1'b0}};
        fs_run_r <= 1'b1;
        fs_req_r <= 1'b0;
      end else if (fs_run_r) begin
        if (s_ack)
          fs_run_r <= 1'b0;
        else if (fs_cnt_r == FAILSAFE_CYCLES[`FS_CNT_W-1:0] - 16'h0001) begin
          fs_run_r <= 1'b0;
          fs_req_r <= 1'b1;
        end else
          fs_cnt_r <= fs_cnt_r + 16'h0001;
      end
    end
  end

  // ==================================================
  // Source vector
  // Gather on-board sources
  wire [`SRC_OR_BASE-1:0] base_src;
  assign base_src = {edge_level_r, s_parity, s_copro, s_ext, s_line,
                     s_pfail & s_mlow, fs_req_r, s_exp, s_tmr,
                     s_ser_rx, s_ser_tx, s_par_gen, s_par_oe, s_par_if, s_bus};

  wire or0 = |(base_src & or0_select_i);
  wire or1 = |(base_src & or1_select_i);
  wire [`SRC_COUNT-1:0] src = {or1, or0, base_src};

  // ==================================================
  // Strap matrix
  function [`DEST_W-1:0] dest_of;
    input [`SRC_COUNT*`DEST_W-1:0] straps;
    input integer                  idx;
    begin
      dest_of = straps[idx*`DEST_W +: `DEST_W];
    end
  endfunction

  integer i;
  integer l;
  reg [`LEVEL_COUNT-1:0] lvl_nxt;
  reg                    nmi_nxt;
  always @* begin
    lvl_nxt = {`LEVEL_COUNT{1'b0}};
    nmi_nxt = 1'b0;
    for (i = 0; i < `SRC_COUNT; i = i + 1) begin
      if (dest_of(route_strap_i, i) == `DEST_NMI)
        nmi_nxt = nmi_nxt | src[i];
      for (l = 0; l < `LEVEL_COUNT; l = l + 1) begin
        if (dest_of(route_strap_i, i) == `DEST_LEVEL_BASE + l[3:0])
          lvl_nxt[l] = lvl_nxt[l] | src[i];
      end
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      controller_request_o <= {`LEVEL_COUNT{1'b0}};
      nmi_request_o        <= 1'b0;
    end else begin
      controller_request_o <= lvl_nxt;
      nmi_request_o        <= nmi_nxt;
    end
  end

endmodule

// ==== dv/irq_router_checker.sv ====
// Purpose: Port assertions for the source router
// Assumes: Straps static while a check is armed
// Notes: Bound into every router instance
`timescale 1ns/10ps
module irq_router_checker #(parameter FAILSAFE_CYCLES = 20) (
  input wire         mclk_i,
  input wire         reset_n_i,
  input wire [7:0]   bus_request_i,
  input wire         par_input_full_i,
  input wire         power_fail_i,
  input wire         mains_low_warning_i,
  input wire         line_clock_i,
  input wire         edge_request_i,
  input wire         bus_command_i,
  input wire         bus_acknowledge_i,
  input wire [111:0] route_strap_i,
  input wire [25:0]  or0_select_i,
  input wire         ram_protect_n_i,
  input wire         ram_access_req_i,
  input wire         ram_access_grant_o,
  input wire [7:0]   controller_request_o,
  input wire         nmi_request_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // Unanswered command age, margin covers sync stages
  reg [7:0] wait_r;
  always @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i) wait_r <= 8'h00;
    else if (!bus_command_i || bus_acknowledge_i) wait_r <= 8'h00;
    else if (wait_r != 8'hff) wait_r <= wait_r + 8'h01;
  property p_grant; ram_access_grant_o == (ram_access_req_i & ram_protect_n_i); endproperty
  a_grant: assert property (p_grant) else $error("ram grant wrong");
  property p_bus; (route_strap_i[3:0] == 4'h1 && $past(bus_request_i[0], 3))
    |-> controller_request_o[0]; endproperty
  a_bus: assert property (p_bus) else $error("bus line not routed");
  property p_pf; (route_strap_i[83:80] == 4'h9 && $past(power_fail_i && mains_low_warning_i, 3))
    |-> nmi_request_o; endproperty
  a_pf: assert property (p_pf) else $error("power fail not on nmi");
  property p_line; (route_strap_i[87:84] == 4'h6 && $past(line_clock_i, 3))
    |-> controller_request_o[5]; endproperty
  a_line: assert property (p_line) else $error("line clock not routed");
  property p_zero; (route_strap_i == 112'h0) [*4] |-> controller_request_o == 8'h00 && !nmi_request_o;
  endproperty
  a_zero: assert property (p_zero) else $error("request without route");
  property p_edge; ($rose(edge_request_i) && route_strap_i[103:100] == 4'h3)
    |-> ##[3:6] controller_request_o[2]; endproperty
  a_edge: assert property (p_edge) else $error("edge not converted");
  property p_or; (or0_select_i[8] && route_strap_i[107:104] == 4'h6 && $past(par_input_full_i, 3)
    && $past(par_input_full_i, 4)) |-> controller_request_o[5]; endproperty
  a_or: assert property (p_or) else $error("or output not routed");
  property p_fs; (route_strap_i[79:76] == 4'h4 && wait_r == FAILSAFE_CYCLES + 8)
    |-> controller_request_o[3]; endproperty
  a_fs: assert property (p_fs) else $error("fail-safe silent");
endmodule
bind irq_source_router irq_router_checker #(.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) chk_u (.*);

// ==== dv/bus_agent.sv ====
// Purpose: System-bus agent answering commands
// Assumes: Delay 8'hff means never answers
// Notes: Command follows go_i one clock later
`timescale 1ns/10ps
module bus_agent (
  input  wire       clk_i,
  input  wire       go_i,
  input  wire [7:0] ack_delay_i,
  output reg        command_o,
  output reg        acknowledge_o
);
  reg [7:0] cnt_r;
  initial {command_o, acknowledge_o, cnt_r} = 10'h000;
  always @(posedge clk_i) begin
    command_o <= go_i;
    cnt_r <= go_i ? cnt_r + {7'h00, cnt_r != 8'hff} : 8'h00;
    acknowledge_o <= go_i && cnt_r >= ack_delay_i && ack_delay_i != 8'hff;
  end
endmodule

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the source router
// Assumes: Fail-safe count shortened to 20 cycles
// Notes: Source 19 is internal, never driven
`timescale 1ns/10ps
module testbench;
  reg mclk_i = 1'b0, reset_n_i, go, edge_in, clr, mains, prot_n, req;
  reg [24:0] src;
  reg [7:0] ack_dly;
  reg [111:0] strap;
  reg [25:0] or0, or1;
  wire cmd, ack, grant, nmi;
  wire [7:0] lvl;
  int errors = 0, cmp_count = 0;
  always #50 mclk_i = ~mclk_i;
  bus_agent agent_u (.clk_i(mclk_i), .go_i(go), .ack_delay_i(ack_dly), .command_o(cmd),
    .acknowledge_o(ack));
  irq_source_router #(.FAILSAFE_CYCLES(20)) dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .bus_request_i(src[7:0]), .par_input_full_i(src[8]), .par_output_empty_i(src[9]),
    .socket_general_request_i(src[10]), .ser_tx_empty_i(src[11]), .ser_rx_full_i(src[12]),
    .timer_out_i(src[14:13]), .expansion_request_i(src[18:15]), .bus_command_i(cmd),
    .bus_acknowledge_i(ack), .power_fail_i(src[20]), .mains_low_warning_i(mains),
    .line_clock_i(src[21]), .auxiliary_backplane_request_i(src[22]), .coproc_error_i(src[23]),
    .parity_error_i(src[24]), .edge_request_i(edge_in), .edge_clear_i(clr),
    .route_strap_i(strap), .or0_select_i(or0), .or1_select_i(or1), .ram_protect_n_i(prot_n),
    .ram_access_req_i(req), .ram_access_grant_o(grant), .controller_request_o(lvl),
    .nmi_request_o(nmi));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n); repeat (n) @(posedge mclk_i); #1; endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Scenarios
  task s_grant;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i) {prot_n, req} <= 2'(k);
      tick(1); check("grant", grant, k == 3);
    end
  endtask
  task s_route;
    for (int i = 0; i < 25; i++) begin
      if (i == 19) continue;
      @(posedge mclk_i) strap <= 112'(i % 8 + 1) << (4 * i);
      src <= 25'h1 << i;
      tick(4); check("route", {nmi, lvl}, 32'h1 << (i % 8));
    end
    @(posedge mclk_i) strap <= 112'h9 << 92;
    src <= 25'h1 << 23;
    tick(4); check("nmi", {nmi, lvl}, 32'h100);
    @(posedge mclk_i) strap <= 112'ha << 92;
    tick(4); check("refused", {nmi, lvl}, 0);
    @(posedge mclk_i) strap <= 112'h9 << 80;
    src <= 25'h1 << 20;
    mains <= 1'b0;
    tick(4); check("pf low", nmi, 0);
    @(posedge mclk_i) mains <= 1'b1;
    tick(4); check("pf", nmi, 1);
  endtask
  task s_edge;
    @(posedge mclk_i) strap <= 112'h3 << 100;
    src <= '0;
    edge_in <= 1'b1;
    @(posedge mclk_i) edge_in <= 1'b0;
    tick(8); check("edge set", lvl, 8'h04);
    @(posedge mclk_i) clr <= 1'b1;
    @(posedge mclk_i) clr <= 1'b0;
    tick(4); check("edge clr", lvl, 0);
  endtask
  task s_or;
    @(posedge mclk_i) strap <= (112'h6 << 104) | (112'h9 << 108);
    {or0, or1, src} <= {26'h100, 26'h200, 25'h100};
    tick(5); check("or0", {nmi, lvl}, 32'h20);
    @(posedge mclk_i) src <= 25'h300;
    tick(5); check("or1", {nmi, lvl}, 32'h120);
  endtask
  task s_fail;
    int n;
    @(posedge mclk_i) strap <= 112'h4 << 76;
    {src, go} <= {25'h0, 1'b1};
    tick(40); check("fs ack", lvl, 0);
    @(posedge mclk_i) go <= 1'b0;
    tick(2);
    @(posedge mclk_i) {ack_dly, go} <= {8'hff, 1'b1};
    for (n = 0; n < 60 && lvl[3] !== 1'b1; n++) tick(1);
    if (n == 60) begin errors++; complete_run; end
    check("fs time", n >= 20 && n <= 26, 1);
    @(posedge mclk_i) go <= 1'b0;
    tick(10); check("fs hold", lvl, 8'h08);
    @(posedge mclk_i) {ack_dly, go} <= {8'h03, 1'b1};
    tick(8); check("fs clear", lvl, 0);
  endtask
  initial begin
    {reset_n_i, src, go, edge_in, clr, strap, or0, or1, req} = '0;
    {mains, prot_n, ack_dly} = {2'h3, 8'h03};
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    tick(4); check("idle", {nmi, lvl}, 0);
    s_grant; s_route; s_edge; s_or; s_fail;
    complete_run;
  end
endmodule
